// >>> hdl/fpb_ctrl.v
// Fragment page buffer control: registers, input path and page queues
`timescale 1ns/100ps
`include "fpb_map.vh"

////////////////////////////////////////////////////////////////////////
module fpb_ctrl #(
  parameter PAGE_BITS = 10,
  parameter WORD_BITS = 8,
  parameter IF_DEPTH = 32,
  parameter IF_AW = 5
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Local processor bus, one word per access
  input wire [`FPB_WIN_BITS-1:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata_r,
  // Link input
  input wire [31:0] link_data,
  input wire link_valid,
  input wire link_ctrl,
  input wire link_lderr,
  input wire link_down,
  output wire link_xoff,
  output wire link_reset,
  output wire [3:0] link_return,
  output wire [1:0] link_width,
  output wire link_test,
  output wire [3:0] user_led,
  // Fragment memory write port
  output reg mem_we_r,
  output reg [PAGE_BITS+WORD_BITS-1:0] mem_addr_r,
  output reg [31:0] mem_wdata_r,
  // Input FIFO fill level
  output wire [11:0] avail_count
);
  localparam EW = 16 + PAGE_BITS;
  localparam S_IDLE = 2'd0;
  localparam S_LOAD = 2'd1;
  localparam S_RUN = 2'd2;

  function sel_is;
    input [`FPB_WIN_BITS-1:0] a;
    input [`FPB_WIN_BITS-1:0] off;
    begin
      sel_is = (a[`FPB_WIN_BITS-1:`FPB_SEL_LSB] ==
        off[`FPB_WIN_BITS-1:`FPB_SEL_LSB]);
    end
  endfunction

  // Registers and state
  reg [31:0] cc_r;
  reg [PAGE_BITS-1:0] fp_thresh_r;
  reg thr_sel_r;
  reg [1:0] st_r;
  reg [PAGE_BITS-1:0] page_r;
  reg [WORD_BITS-1:0] word_r;
  reg in_frag_r;
  reg [5:0] acc_r;
  reg bob_no_eob_r;
  reg eob_no_bob_r;
  reg data_no_bob_r;
  reg [IF_AW:0] if_thresh_r;
  reg up_wr_r;
  reg [EW-1:0] up_wdata_r;
  reg fp_rd;
  reg [31:0] rd_nxt;

  wire test_en;
  wire wr_td;
  wire wr_tde;
  wire wr_tc;
  wire wr_tce;
  wire test_wr;
  wire [33:0] if_in;
  wire if_in_valid;
  wire if_in_ready;
  wire [33:0] if_out;
  wire if_out_valid;
  wire if_out_ready;
  wire [IF_AW:0] if_level;
  wire if_empty;
  wire if_half;
  wire if_almost_full;
  wire fp_empty;
  wire fp_ae;
  wire [PAGE_BITS-1:0] fp_page;
  wire up_empty;
  wire up_full;
  wire [EW-1:0] up_rdata;
  wire err_any;
  wire [7:0] live_hi;
  wire is_bob;
  wire is_eob;
  wire last_word;
  wire close_now;

  //////////////////////////////////////////////////////////////////////
  // Address decode over the partially decoded window
  assign test_en = cc_r[`FPB_CC_TEST_EN];
  assign wr_td = bus_wr & sel_is(bus_addr, `FPB_OFF_TD);
  assign wr_tde = bus_wr & sel_is(bus_addr, `FPB_OFF_TDE);
  assign wr_tc = bus_wr & sel_is(bus_addr, `FPB_OFF_TC);
  assign wr_tce = bus_wr & sel_is(bus_addr, `FPB_OFF_TCE);
  assign test_wr = test_en & (wr_td | wr_tde | wr_tc | wr_tce);

  // Control register; bits 3:0 come up set, holding the queue, FIFO and link resets and transmit-off
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cc_r <= `FPB_CC_RESET;
      fp_thresh_r <= `FPB_FP_THRESH_RESET;
      thr_sel_r <= 1'b0;
      if_thresh_r <= IF_DEPTH[IF_AW:0] - 1'b1;
    end else begin
      if (bus_wr && sel_is(bus_addr, `FPB_OFF_CARD_CTRL)) begin
        cc_r <= bus_wdata & 32'hf000_1fdf;
      end
      // Loads alternate empty then full offset; only empty is used
      if (bus_wr && sel_is(bus_addr, `FPB_OFF_FP_THRESH)) begin
        thr_sel_r <= ~thr_sel_r;
        if (!thr_sel_r) begin
          fp_thresh_r <= bus_wdata[PAGE_BITS-1:0];
        end
      end
      // Threshold load is a test port too, gated the same way
      if (test_en && bus_wr && sel_is(bus_addr, `FPB_OFF_IN_THRESH)) begin
        if_thresh_r <= bus_wdata[IF_AW:0];
      end
    end
  end

  assign link_reset = cc_r[`FPB_CC_LRESET];
  assign link_return = cc_r[11:8];
  assign link_width = cc_r[7:6];
  assign link_test = cc_r[4];
  assign user_led = cc_r[31:28];

  //////////////////////////////////////////////////////////////////////
  // Input FIFO: link words, or test words with forced marker bits
  // Test writes win over the link; a link word in the same cycle is lost
  assign if_in = test_wr ?
    {wr_tde | wr_tce, wr_tc | wr_tce, bus_wdata} :
    {link_lderr, link_ctrl, link_data};
  assign if_in_valid = test_wr | (link_valid & ~link_reset);

  fpb_fifo #(
    .WIDTH(34),
    .DEPTH(IF_DEPTH),
    .AW(IF_AW)
  ) u_in_fifo (
    .clock(clock),
    .nrst(nrst),
    .clr(cc_r[`FPB_CC_IF_RST]),
    .in_data(if_in),
    .in_valid(if_in_valid),
    .in_ready(if_in_ready),
    .out_data(if_out),
    .out_valid(if_out_valid),
    .out_ready(if_out_ready),
    .level_r(if_level)
  );

  assign if_empty = ~if_out_valid;
  assign if_half = (if_level >= (IF_DEPTH / 2));
  assign if_almost_full = (if_level >= if_thresh_r);

  //////////////////////////////////////////////////////////////////////
  // Free and used page queues
  fpb_page_queue #(
    .WIDTH(PAGE_BITS),
    .DEPTH(1 << PAGE_BITS),
    .AW(PAGE_BITS)
  ) u_free_q (
    .clock(clock),
    .nrst(nrst),
    .clr(cc_r[`FPB_CC_Q_RST]),
    .wr(bus_wr & sel_is(bus_addr, `FPB_OFF_FREE_PAGE)),
    .wdata(bus_wdata[PAGE_BITS-1:0]),
    .rd(fp_rd),
    .rdata(fp_page),
    .ae_thresh(fp_thresh_r),
    .empty(fp_empty),
    .full(),
    .almost_empty_flag(fp_ae)
  );

  fpb_page_queue #(
    .WIDTH(EW),
    .DEPTH(1 << PAGE_BITS),
    .AW(PAGE_BITS)
  ) u_used_q (
    .clock(clock),
    .nrst(nrst),
    .clr(cc_r[`FPB_CC_Q_RST]),
    .wr(up_wr_r),
    .wdata(up_wdata_r),
    .rd(bus_rd & sel_is(bus_addr, `FPB_OFF_USED_PAGE)),
    .rdata(up_rdata),
    .ae_thresh({PAGE_BITS{1'b0}}),
    .empty(up_empty),
    .full(up_full),
    .almost_empty_flag()
  );

  //////////////////////////////////////////////////////////////////////
  // Transmit-off: control bit, free pages low, input FIFO filling
  assign link_xoff = cc_r[`FPB_CC_XOFF] | fp_ae |
    if_half | if_almost_full;

  //////////////////////////////////////////////////////////////////////
  // Page writer: one word per cycle, page number from the free queue
  assign is_bob = if_out[32] & (if_out[31:28] == `FPB_CW_BOB);
  assign is_eob = if_out[32] & (if_out[31:28] == `FPB_CW_EOB);
  assign last_word = (word_r == {WORD_BITS{1'b1}});
  // A stalled used queue holds the writer rather than losing entries
  assign if_out_ready = (st_r == S_RUN) & ~up_full;
  assign close_now = if_out_ready & if_out_valid &
    (is_eob | last_word);

  // Writer sequence; the memory address counts in words
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_IDLE;
      page_r <= {PAGE_BITS{1'b0}};
      word_r <= {WORD_BITS{1'b0}};
      fp_rd <= 1'b0;
      in_frag_r <= 1'b0;
      acc_r <= 6'h00;
      bob_no_eob_r <= 1'b0;
      eob_no_bob_r <= 1'b0;
      data_no_bob_r <= 1'b0;
      up_wr_r <= 1'b0;
      up_wdata_r <= {EW{1'b0}};
      mem_we_r <= 1'b0;
      mem_addr_r <= {(PAGE_BITS+WORD_BITS){1'b0}};
      mem_wdata_r <= 32'h0000_0000;
    end else if (cc_r[`FPB_CC_Q_RST] || cc_r[`FPB_CC_IF_RST]) begin
      st_r <= S_IDLE;
      word_r <= {WORD_BITS{1'b0}};
      fp_rd <= 1'b0;
      in_frag_r <= 1'b0;
      acc_r <= 6'h00;
      bob_no_eob_r <= 1'b0;
      eob_no_bob_r <= 1'b0;
      data_no_bob_r <= 1'b0;
      up_wr_r <= 1'b0;
      mem_we_r <= 1'b0;
    end else begin
      fp_rd <= 1'b0;
      up_wr_r <= 1'b0;
      mem_we_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (!fp_empty) begin
            page_r <= fp_page;
            fp_rd <= 1'b1;
            word_r <= {WORD_BITS{1'b0}};
            acc_r <= 6'h00;
            st_r <= S_LOAD;
          end
        end
        S_LOAD: begin
          st_r <= S_RUN;
        end
        S_RUN: begin
          if (if_out_ready && if_out_valid) begin
            mem_we_r <= 1'b1;
            mem_addr_r <= {page_r, word_r};
            mem_wdata_r <= if_out[31:0];
            // Framing checks update the live flags
            if (is_bob) begin
              in_frag_r <= 1'b1;
              bob_no_eob_r <= in_frag_r;
            end else if (is_eob) begin
              in_frag_r <= 1'b0;
              eob_no_bob_r <= ~in_frag_r;
            end else begin
              data_no_bob_r <= ~in_frag_r;
            end
            // Page flags accumulate over every word
            acc_r <= acc_r | {if_out[33], 1'b0,
              ~is_bob & ~is_eob & ~in_frag_r,
              is_eob & ~in_frag_r, is_bob & in_frag_r,
              if_almost_full};
            if (close_now) begin
              // Queue the last word address with its status
              up_wr_r <= 1'b1;
              up_wdata_r <= {{(16 - 6 - WORD_BITS){1'b0}},
                acc_r[5] | if_out[33], is_eob,
                acc_r[3] | (~is_bob & ~is_eob & ~in_frag_r),
                acc_r[2] | (is_eob & ~in_frag_r),
                acc_r[1] | (is_bob & in_frag_r),
                acc_r[0] | if_almost_full,
                page_r, word_r};
              st_r <= S_IDLE;
            end else begin
              word_r <= word_r + 1'b1;
            end
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status and read path
  assign err_any = bob_no_eob_r | eob_no_bob_r | data_no_bob_r |
    acc_r[5];
  assign live_hi = {up_empty, err_any, fp_empty, bob_no_eob_r,
    eob_no_bob_r, data_no_bob_r, link_down, if_half};
  assign avail_count = {{(12 - IF_AW - 1){1'b0}}, if_level};

  // Read data is registered; queue read shows live bits on top
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (sel_is(bus_addr, `FPB_OFF_STATUS)) begin
      rd_nxt = {live_hi, if_out_valid, if_empty, link_xoff,
        9'h000, avail_count};
    end else if (sel_is(bus_addr, `FPB_OFF_USED_PAGE)) begin
      // Queued bits are stale while the empty bit is set
      rd_nxt = {live_hi, up_rdata[23:0]};
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_rdata_r <= 32'h0000_0000;
    end else if (bus_rd) begin
      bus_rdata_r <= rd_nxt;
    end
  end
endmodule // fpb_ctrl

// >>> hdl/fpb_map.vh
// Register offsets, field positions and reset values
`ifndef FPB_MAP_VH
`define FPB_MAP_VH
// Decoded window: bits 21:16 of the local address
`define FPB_WIN_BITS 22
`define FPB_SEL_LSB 16
`define FPB_OFF_FREE_PAGE 22'h20_0000
`define FPB_OFF_IN_THRESH 22'h21_0000
`define FPB_OFF_CARD_CTRL 22'h22_0000
`define FPB_OFF_FP_THRESH 22'h24_0000
`define FPB_OFF_STATUS 22'h26_0000
`define FPB_OFF_USED_PAGE 22'h2a_0000
`define FPB_OFF_TD 22'h2c_0000
`define FPB_OFF_TDE 22'h2d_0000
`define FPB_OFF_TC 22'h2e_0000
`define FPB_OFF_TCE 22'h2f_0000
// Card control fields
`define FPB_CC_TEST_EN 12
`define FPB_CC_XOFF 3
`define FPB_CC_LRESET 2
`define FPB_CC_IF_RST 1
`define FPB_CC_Q_RST 0
`define FPB_CC_RESET 32'h0000_000f
// Status fields
`define FPB_ST_UQ_EMPTY 31
`define FPB_ST_ERR 30
`define FPB_ST_FQ_EMPTY 29
`define FPB_ST_BOB_NO_EOB 28
`define FPB_ST_EOB_NO_BOB 27
`define FPB_ST_DATA_NO_BOB 26
`define FPB_ST_LDOWN 25
`define FPB_ST_IF_HALF 24
`define FPB_ST_IN_AVAIL 23
`define FPB_ST_IF_EMPTY 22
`define FPB_ST_XOFF 21
// Used-page entry fields
`define FPB_UP_LDERR 23
`define FPB_UP_LAST 22
`define FPB_UP_FLAGS_LSB 18
`define FPB_UP_PAGE_LSB 8
`define FPB_FP_THRESH_RESET 10'h07f
// Control word codes in the top nibble of a control word
`define FPB_CW_BOB 4'h1
`define FPB_CW_EOB 4'h2
`endif

// >>> hdl/fpb_fifo.v
// Synchronous valid/ready FIFO with parameter width and depth
`timescale 1ns/100ps
module fpb_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  input wire clr,
  // Fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  // Fill level
  output reg [AW:0] level_r
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  wire push;
  wire pop;

  assign in_ready = (level_r != DEPTH[AW:0]);
  assign out_valid = (level_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset so it can map to RAM
  always @(posedge clock) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Pointers wrap only for power-of-two depth
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      level_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      level_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      level_r <= level_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // fpb_fifo

// >>> hdl/fpb_page_queue.v
// Page queue: simple FIFO with programmable almost-empty threshold
`timescale 1ns/100ps
module fpb_page_queue #(
  parameter WIDTH = 18,
  parameter DEPTH = 1024,
  parameter AW = 10
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  input wire clr,
  // Write side
  input wire wr,
  input wire [WIDTH-1:0] wdata,
  // Read side
  input wire rd,
  output wire [WIDTH-1:0] rdata,
  // Flags
  input wire [AW-1:0] ae_thresh,
  output wire empty,
  output wire full,
  output wire almost_empty_flag
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;

  assign empty = (cnt_r == {(AW+1){1'b0}});
  assign full = (cnt_r == DEPTH[AW:0]);
  assign rdata = mem[rp_r];
  // Flag stays up until threshold+2 entries are held
  assign almost_empty_flag = (cnt_r <= {1'b0, ae_thresh} + 1'b1);

  always @(posedge clock) begin
    if (wr && !full) begin
      mem[wp_r] <= wdata;
    end
  end

  // Count and pointers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (wr && !full) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd && !empty) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, wr & ~full}
        - {{AW{1'b0}}, rd & ~empty};
    end
  end
endmodule // fpb_page_queue

// >>> sim/fpb_ctrl_sva.sv
// Port-level assertions for the fragment page buffer control
`timescale 1ns/100ps
module fpb_ctrl_sva #(
  parameter PAGE_BITS = 10,
  parameter WORD_BITS = 8,
  parameter IF_DEPTH = 32
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Processor bus
  input wire [21:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_wdata,
  input wire [31:0] bus_rdata_r,
  // Link
  input wire link_valid,
  input wire link_down,
  input wire link_xoff,
  input wire link_reset,
  // Fragment memory and fill level
  input wire mem_we_r,
  input wire [PAGE_BITS+WORD_BITS-1:0] mem_addr_r,
  input wire [11:0] avail_count
);
  localparam AW = PAGE_BITS + WORD_BITS;
  localparam WB = WORD_BITS;
  reg [31:0] ctrl_r;
  reg lv_r;
  reg [AW-1:0] last_r;
  wire st_rd = bus_rd && bus_addr[21:16] == 6'h26;
  wire uq_rd = bus_rd && bus_addr[21:16] == 6'h2a;
  //////////////////////////////////////////////////////////////////////
  // Shadow of card control, which software cannot read back
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      ctrl_r <= 32'h0000_000f;
    else if (bus_wr && bus_addr[21:16] == 6'h22)
      ctrl_r <= bus_wdata;
  end
  // Last memory address written, to follow the address generator
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lv_r <= 1'b0;
      last_r <= {AW{1'b0}};
    end else if (mem_we_r) begin
      lv_r <= 1'b1;
      last_r <= mem_addr_r;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_xoff_ctrl; ctrl_r[3] |-> link_xoff; endproperty
  a_xoff_ctrl: assert property (p_xoff_ctrl)
    else $error("transmit-off low while forced");
  property p_xoff_half; avail_count > (IF_DEPTH / 2) |-> link_xoff;
  endproperty
  a_xoff_half: assert property (p_xoff_half)
    else $error("transmit-off low with input FIFO past half");
  property p_lreset; link_reset == ctrl_r[2]; endproperty
  a_lreset: assert property (p_lreset)
    else $error("link reset differs from control bit");
  property p_st_xoff; st_rd |=> bus_rdata_r[21] == $past(link_xoff);
  endproperty
  a_st_xoff: assert property (p_st_xoff)
    else $error("status transmit-off bit wrong");
  property p_st_live;
    st_rd |=> bus_rdata_r[25] == $past(link_down) &&
      bus_rdata_r[11:0] == $past(avail_count);
  endproperty
  a_st_live: assert property (p_st_live)
    else $error("status live bits wrong");
  property p_uq_live; uq_rd |=> bus_rdata_r[25] == $past(link_down);
  endproperty
  a_uq_live: assert property (p_uq_live)
    else $error("queue read lacks live link state");
  property p_word_inc;
    mem_we_r && lv_r && mem_addr_r[AW-1:WB] == last_r[AW-1:WB] |->
      mem_addr_r[WB-1:0] == last_r[WB-1:0] + 1'b1;
  endproperty
  a_word_inc: assert property (p_word_inc)
    else $error("word address did not step by one");
  property p_page_start;
    mem_we_r && (!lv_r || mem_addr_r[AW-1:WB] != last_r[AW-1:WB]) |->
      mem_addr_r[WB-1:0] == 0;
  endproperty
  a_page_start: assert property (p_page_start)
    else $error("new page not started at word zero");
  property p_gate;
    bus_wr && bus_addr[21:18] == 4'hb && !ctrl_r[12] && !link_valid &&
      avail_count == 12'd0 |=> (avail_count == 12'd0) [*3];
  endproperty
  a_gate: assert property (p_gate)
    else $error("test word entered with test input off");
endmodule // fpb_ctrl_sva

bind fpb_ctrl fpb_ctrl_sva #(.PAGE_BITS(PAGE_BITS),
  .WORD_BITS(WORD_BITS), .IF_DEPTH(IF_DEPTH)) u_sva (
  .clock(clock), .nrst(nrst), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r),
  .link_valid(link_valid), .link_down(link_down), .link_xoff(link_xoff),
  .link_reset(link_reset), .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r),
  .avail_count(avail_count));

// >>> sim/fpb_link_src.sv
// Behavioural link source: sends words and reports link state
`timescale 1ns/100ps
module fpb_link_src (
  // Clock
  input wire clock,
  // Control from the buffer
  input wire link_reset,
  input wire link_xoff,
  // Words toward the buffer
  output reg [31:0] link_data,
  output reg link_valid,
  output reg link_ctrl,
  output reg link_lderr,
  output reg link_down
);
  integer rst_cnt;
  initial begin
    link_data = 32'h0000_0000;
    link_valid = 1'b0;
    link_ctrl = 1'b0;
    link_lderr = 1'b0;
    link_down = 1'b1;
    rst_cnt = 0;
  end
  //////////////////////////////////////////////////////////////////////
  // Link comes up only after reset has been held for a while
  always @(negedge clock) begin
    if (link_reset && rst_cnt < 40)
      rst_cnt = rst_cnt + 1;
    if (rst_cnt == 40)
      link_down = 1'b0;
  end
  // One word per call; idle lines show inverted data, not the last word
  task send(input [31:0] d, input c);
    @(negedge clock);
    while (link_xoff)
      @(negedge clock);
    link_data = d;
    link_ctrl = c;
    link_valid = 1'b1;
    @(negedge clock);
    link_valid = 1'b0;
    link_ctrl = 1'b0;
    link_data = ~d;
  endtask
endmodule // fpb_link_src

// >>> sim/fragment_page_buffer_status_test.sv
// Self-checking bench for the fragment page buffer control
`timescale 1ns/100ps
module fragment_page_buffer_status_test;
  localparam [21:0] FPQ = 22'h20_0000, CTRL = 22'h22_0000;
  localparam [21:0] THR = 22'h24_0000, ST = 22'h26_0000;
  localparam [21:0] UQ = 22'h2a_0000, TD = 22'h2c_0000;
  localparam [21:0] TDE = 22'h2d_0000, TC = 22'h2e_0000;
  localparam [21:0] TCE = 22'h2f_0000;
  reg clock, nrst, bus_wr, bus_rd;
  reg [21:0] bus_addr;
  reg [31:0] bus_wdata, rd_d;
  wire [31:0] bus_rdata_r, link_data, mem_wdata_r;
  wire link_valid, link_ctrl, link_lderr, link_down, link_xoff;
  wire link_reset, mem_we_r;
  wire [17:0] mem_addr_r;
  wire [11:0] avail_count;
  wire [3:0] link_return, user_led;
  wire [1:0] link_width;
  wire link_test;
  integer error_cnt = 0, checks = 0, cyc = 0, i;
  reg [49:0] cap [$];
  fpb_ctrl dut (.clock(clock), .nrst(nrst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata_r(bus_rdata_r), .link_data(link_data),
    .link_valid(link_valid), .link_ctrl(link_ctrl),
    .link_lderr(link_lderr), .link_down(link_down),
    .link_xoff(link_xoff), .link_reset(link_reset),
    .link_return(link_return), .link_width(link_width),
    .link_test(link_test), .user_led(user_led), .mem_we_r(mem_we_r),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
    .avail_count(avail_count));
  fpb_link_src u_link (.clock(clock), .link_reset(link_reset),
    .link_xoff(link_xoff), .link_data(link_data),
    .link_valid(link_valid), .link_ctrl(link_ctrl),
    .link_lderr(link_lderr), .link_down(link_down));
  //////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Record memory writes; cut a hang short well past the expected run
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (mem_we_r)
      cap.push_back({mem_addr_r, mem_wdata_r});
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [49:0] got, input [49:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Whole 32-bit words only; an idle cycle follows so strobes never abut
  task wr(input [21:0] a, input [31:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clock);
    bus_wr = 1'b0;
    @(negedge clock);
  endtask
  task rd(input [21:0] a);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clock);
    bus_rd = 1'b0;
    rd_d = bus_rdata_r;
    @(negedge clock);
  endtask
  // Missing write is forced to mismatch by comparing with its inverse
  task mchk(input [17:0] a, input [31:0] d);
    if (cap.size() == 0)
      cap.push_back(~{a, d});
    chk(cap.pop_front(), {a, d});
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(ST);
    chk(rd_d, 32'ha260_0000);
    rd(UQ | 22'h00_abcd);
    chk(rd_d[31:24], 8'ha2);
  endtask
  // Software link reset: hold reset, poll link down, then release
  task t_link_up;
    wr(CTRL, 32'h0000_000c);
    rd(ST);
    for (i = 0; i < 100 && rd_d[25]; i = i + 1)
      rd(ST);
    chk(rd_d[25], 1'b0);
    wr(CTRL, 32'h0000_0008);
    chk(link_reset, 1'b0);
    wr(TD, 32'h1234_5678);
    repeat (10) @(negedge clock);
    chk(avail_count, 12'h000);
  endtask
  // No free page: input FIFO fills and refuses, then drains into a page
  task t_fill;
    wr(CTRL, 32'h0000_1000);
    for (i = 0; i < 33; i = i + 1)
      wr(TD, 32'h5000_0000 + i);
    rd(ST);
    chk(rd_d & 32'h01e0_0fff, 32'h01a0_0020);
    wr(FPQ, 32'h0000_0005);
    repeat (60) @(negedge clock);
    for (i = 0; i < 32; i = i + 1)
      mchk({10'd5, i[7:0]}, 32'h5000_0000 + i);
    rd(ST);
    chk(rd_d & 32'h4c40_0fff, 32'h4440_0000);
    wr(TC, 32'h2000_0000);
    repeat (10) @(negedge clock);
    mchk({10'd5, 8'd32}, 32'h2000_0000);
    rd(UQ);
    chk(rd_d & 32'h08ff_ffff, 32'h0874_0520);
    wr(CTRL, 32'h0000_1003);
    wr(CTRL, 32'h0000_1000);
    rd(ST);
    chk(rd_d & 32'hfc00_0000, 32'ha000_0000);
  endtask
  // Almost-empty threshold 0: flag holds until two pages are queued
  task t_thresh;
    wr(THR, 32'h0000_0000);
    for (i = 6; i < 9; i = i + 1) begin
      wr(FPQ, i);
      repeat (4) @(negedge clock);
      chk(link_xoff, i < 8);
    end
    wr(CTRL, 32'hf000_1fd8);
    chk(link_xoff, 1'b1);
    chk({user_led, link_return, link_width, link_test}, 11'h7ff);
    wr(CTRL, 32'h0000_1000);
    chk({user_led, link_return, link_width, link_test}, 11'h000);
  endtask
  // Error on a middle word must still show in the page entry
  task t_frag_mixed;
    wr(TC, 32'h1000_0000);
    wr(TD, 32'h1111_0001);
    wr(TDE, 32'h2222_0002);
    wr(TC, 32'h2000_0000);
    repeat (10) @(negedge clock);
    mchk(18'h00600, 32'h1000_0000);
    mchk(18'h00601, 32'h1111_0001);
    mchk(18'h00602, 32'h2222_0002);
    mchk(18'h00603, 32'h2000_0000);
    rd(UQ);
    chk({rd_d[31], rd_d[23:0]}, {1'b0, 24'hc0_0603});
  endtask
  task t_frag_err_ctrl;
    wr(TCE, 32'h1000_0000);
    wr(TC, 32'h2000_0000);
    repeat (10) @(negedge clock);
    mchk(18'h00700, 32'h1000_0000);
    mchk(18'h00701, 32'h2000_0000);
    rd(UQ);
    chk({rd_d[31], rd_d[23:0]}, {1'b0, 24'hc0_0701});
  endtask
  // Frame over the link into page 8, then the queue reads empty
  task t_link_frame;
    wr(FPQ, 32'h0000_0009);
    wr(FPQ, 32'h0000_000a);
    u_link.send(32'h1000_0000, 1'b1);
    u_link.send(32'haaaa_0001, 1'b0);
    u_link.send(32'h2000_0000, 1'b1);
    repeat (10) @(negedge clock);
    mchk(18'h00800, 32'h1000_0000);
    mchk(18'h00801, 32'haaaa_0001);
    mchk(18'h00802, 32'h2000_0000);
    rd(UQ);
    chk({rd_d[31], rd_d[23:0]}, {1'b0, 24'h40_0802});
    rd(UQ);
    chk(rd_d[31], 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 22'h00_0000;
    bus_wdata = 32'h0000_0000;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    t_reset;
    t_link_up;
    t_fill;
    t_thresh;
    t_frag_mixed;
    t_frag_err_ctrl;
    t_link_frame;
    tally_and_finish;
  end
endmodule // fragment_page_buffer_status_test
